//--- core/iplr_defines.vh
// constants for the interrupt priority level register block
`ifndef IPLR_DEFINES_VH
`define IPLR_DEFINES_VH

// bus geometry
`define IPLR_AW 8
`define IPLR_DW 32
`define IPLR_RW 16

// register indices, as printed; the byte address is four times the index
`define IPLR_IDX_ZERO 6'h00
`define IPLR_IDX_FLASH_PORTD 6'h01
`define IPLR_IDX_SERIAL_PORTS 6'h02
`define IPLR_IDX_I2C_ERR_SERIAL 6'h03
`define IPLR_IDX_TIMER_I2C 6'h04

// byte addresses on the bus
`define IPLR_ADDR_ZERO {`IPLR_IDX_ZERO, 2'h0}
`define IPLR_ADDR_FLASH_PORTD {`IPLR_IDX_FLASH_PORTD, 2'h0}
`define IPLR_ADDR_SERIAL_PORTS {`IPLR_IDX_SERIAL_PORTS, 2'h0}
`define IPLR_ADDR_I2C_ERR_SERIAL {`IPLR_IDX_I2C_ERR_SERIAL, 2'h0}
`define IPLR_ADDR_TIMER_I2C {`IPLR_IDX_TIMER_I2C, 2'h0}

// writable bit masks; cleared bits are reserved or outside this block
`define IPLR_MASK_ZERO 16'h000F
`define IPLR_MASK_FLASH_PORTD 16'hC03F
`define IPLR_MASK_SERIAL_PORTS 16'hC3FF
`define IPLR_MASK_I2C_ERR_SERIAL 16'hC03F
`define IPLR_MASK_TIMER_I2C 16'hFFFF

// reset value of every priority register: all sources disabled
`define IPLR_RESET_VAL 16'h0000

// field codes
`define IPLR_FIELD_OFF 2'h0
`define IPLR_FIELD_W 2
`define IPLR_LOWER_BIAS 2'h1

// number of sources and how many of them (the lowest indices) use the upper range
`define IPLR_NUM_SRC 24
`define IPLR_NUM_UPPER 2

`endif

//--- core/iplr_level_dec.v
// one priority field decoder with registered level, enable and gated request
`timescale 1ns/10ps
`default_nettype none
`include "iplr_defines.vh"

module iplr_level_dec #(
	parameter UPPER_RANGE = 0 // 1: codes map to levels 1..3, 0: codes map to levels 0..2
) (
	input wire clk_i,
	input wire nrst_i,
	input wire [`IPLR_FIELD_W-1:0] field_next_i, // value the field takes at this edge
	input wire irq_i, // raw request of the source
	output reg en_o, // field is nonzero
	output reg [`IPLR_FIELD_W-1:0] level_o, // decoded priority level
	output reg req_o // request passed on to arbitration
);

	wire en_next; // any nonzero code enables
	reg [`IPLR_FIELD_W-1:0] level_next; // decoded level

	assign en_next = (field_next_i != `IPLR_FIELD_OFF);

	// decode; a disabled field shows level zero so no stale level lingers
	always @* begin
		if (!en_next) begin
			level_next = `IPLR_FIELD_OFF;
		end else if (UPPER_RANGE != 0) begin
			level_next = field_next_i;
		end else begin
			level_next = field_next_i - `IPLR_LOWER_BIAS;
		end
	end

	// outputs follow the field in the same edge the field is written
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			en_o <= 1'b0;
			level_o <= `IPLR_FIELD_OFF;
			req_o <= 1'b0;
		end else begin
			en_o <= en_next;
			level_o <= level_next;
			req_o <= irq_i & en_next;
		end
	end

endmodule // iplr_level_dec
`default_nettype wire

//--- core/iplr_regs.v
// interrupt priority level registers with apb access and per-source level outputs
`timescale 1ns/10ps
`default_nettype none
`include "iplr_defines.vh"

module iplr_regs (
	input wire clk_i,
	input wire nrst_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [`IPLR_AW-1:0] paddr_i,
	input wire [`IPLR_DW-1:0] pwdata_i,
	input wire [`IPLR_NUM_SRC-1:0] src_irq_i, // raw requests, one per source
	output reg [`IPLR_DW-1:0] prdata_o,
	output reg pready_o,
	output reg pslverr_o,
	output wire [`IPLR_NUM_SRC-1:0] src_en_o, // source enabled
	output wire [`IPLR_NUM_SRC*`IPLR_FIELD_W-1:0] src_level_o, // decoded levels
	output wire [`IPLR_NUM_SRC-1:0] src_req_o // gated requests
);

	// stored registers; only writable bits ever hold ones
	reg [`IPLR_RW-1:0] irq_level_reg_zero_reg; // debug fields, low nibble only
	reg [`IPLR_RW-1:0] irq_level_flash_portd_reg; // flash and port d
	reg [`IPLR_RW-1:0] irq_level_serial_ports_reg; // serial and ports a..c
	reg [`IPLR_RW-1:0] irq_level_i2c_err_serial_reg; // i2c error and async serial
	reg [`IPLR_RW-1:0] irq_level_timer_i2c_reg; // timer a and i2c

	// next values
	reg [`IPLR_RW-1:0] irq_level_reg_zero_next;
	reg [`IPLR_RW-1:0] irq_level_flash_portd_next;
	reg [`IPLR_RW-1:0] irq_level_serial_ports_next;
	reg [`IPLR_RW-1:0] irq_level_i2c_err_serial_next;
	reg [`IPLR_RW-1:0] irq_level_timer_i2c_next;

	// bus answer next values
	reg [`IPLR_DW-1:0] prdata_next;
	reg pready_next;
	reg pslverr_next;

	// address decode
	wire setup_phase; // first cycle of a transfer
	wire access_done; // edge at which the transfer completes
	reg addr_hit; // address names one of our registers
	reg [`IPLR_RW-1:0] rd_word; // register addressed, as read

	// named views of the stored fields
	wire [`IPLR_FIELD_W-1:0] debug_breakpoint_level;
	wire [`IPLR_FIELD_W-1:0] debug_step_counter_level;
	wire [`IPLR_FIELD_W-1:0] port_d_pin_level;
	wire [`IPLR_FIELD_W-1:0] flash_buffers_empty_level;
	wire [`IPLR_FIELD_W-1:0] flash_cmd_complete_level;
	wire [`IPLR_FIELD_W-1:0] flash_error_level;
	wire [`IPLR_FIELD_W-1:0] async_serial_tx_empty_level;
	wire [`IPLR_FIELD_W-1:0] sync_serial_tx_empty_level;
	wire [`IPLR_FIELD_W-1:0] sync_serial_rx_full_level;
	wire [`IPLR_FIELD_W-1:0] port_a_pin_level;
	wire [`IPLR_FIELD_W-1:0] port_b_pin_level;
	wire [`IPLR_FIELD_W-1:0] port_c_pin_level;
	wire [`IPLR_FIELD_W-1:0] i2c_error_level;
	wire [`IPLR_FIELD_W-1:0] async_serial_rx_full_level;
	wire [`IPLR_FIELD_W-1:0] async_serial_rx_error_level;
	wire [`IPLR_FIELD_W-1:0] async_serial_tx_idle_level;
	wire [`IPLR_FIELD_W-1:0] timer_a_ch3_level;
	wire [`IPLR_FIELD_W-1:0] timer_a_ch2_level;
	wire [`IPLR_FIELD_W-1:0] timer_a_ch1_level;
	wire [`IPLR_FIELD_W-1:0] timer_a_ch0_level;
	wire [`IPLR_FIELD_W-1:0] i2c_status_level;
	wire [`IPLR_FIELD_W-1:0] i2c_transmit_level;
	wire [`IPLR_FIELD_W-1:0] i2c_receive_level;
	wire [`IPLR_FIELD_W-1:0] i2c_general_call_level;

	// field values as they will be after this edge, in source order
	wire [`IPLR_NUM_SRC*`IPLR_FIELD_W-1:0] field_next_all;

	// register zero holds only the debug fields in this block
	assign debug_breakpoint_level = irq_level_reg_zero_reg[3:2];
	assign debug_step_counter_level = irq_level_reg_zero_reg[1:0];

	// flash and port d register
	assign port_d_pin_level = irq_level_flash_portd_reg[15:14];
	assign flash_buffers_empty_level = irq_level_flash_portd_reg[5:4];
	assign flash_cmd_complete_level = irq_level_flash_portd_reg[3:2];
	assign flash_error_level = irq_level_flash_portd_reg[1:0];

	// serial and port register
	assign async_serial_tx_empty_level = irq_level_serial_ports_reg[15:14];
	assign sync_serial_tx_empty_level = irq_level_serial_ports_reg[9:8];
	assign sync_serial_rx_full_level = irq_level_serial_ports_reg[7:6];
	assign port_a_pin_level = irq_level_serial_ports_reg[5:4];
	assign port_b_pin_level = irq_level_serial_ports_reg[3:2];
	assign port_c_pin_level = irq_level_serial_ports_reg[1:0];

	// i2c error and async serial register
	assign i2c_error_level = irq_level_i2c_err_serial_reg[15:14];
	assign async_serial_rx_full_level = irq_level_i2c_err_serial_reg[5:4];
	assign async_serial_rx_error_level = irq_level_i2c_err_serial_reg[3:2];
	assign async_serial_tx_idle_level = irq_level_i2c_err_serial_reg[1:0];

	// timer and i2c register, fully writable
	assign timer_a_ch3_level = irq_level_timer_i2c_reg[15:14];
	assign timer_a_ch2_level = irq_level_timer_i2c_reg[13:12];
	assign timer_a_ch1_level = irq_level_timer_i2c_reg[11:10];
	assign timer_a_ch0_level = irq_level_timer_i2c_reg[9:8];
	assign i2c_status_level = irq_level_timer_i2c_reg[7:6];
	assign i2c_transmit_level = irq_level_timer_i2c_reg[5:4];
	assign i2c_receive_level = irq_level_timer_i2c_reg[3:2];
	assign i2c_general_call_level = irq_level_timer_i2c_reg[1:0];

	// the slave answers with no wait state; prdata and pready come from flops loaded in the setup cycle
	assign setup_phase = psel_i & ~penable_i;
	assign access_done = psel_i & penable_i & pready_o;

	// address decode and read selection; misaligned or unknown addresses miss
	always @* begin
		addr_hit = 1'b1;
		rd_word = `IPLR_RESET_VAL;
		case (paddr_i)
			`IPLR_ADDR_ZERO: begin
				rd_word = irq_level_reg_zero_reg;
			end
			`IPLR_ADDR_FLASH_PORTD: begin
				rd_word = irq_level_flash_portd_reg;
			end
			`IPLR_ADDR_SERIAL_PORTS: begin
				rd_word = irq_level_serial_ports_reg;
			end
			`IPLR_ADDR_I2C_ERR_SERIAL: begin
				rd_word = irq_level_i2c_err_serial_reg;
			end
			`IPLR_ADDR_TIMER_I2C: begin
				rd_word = irq_level_timer_i2c_reg;
			end
			default: begin
				addr_hit = 1'b0; // unmapped: error answer, read zero
			end
		endcase
	end

	// bus answer, prepared during the setup cycle and shown during the access cycle
	always @* begin
		pready_next = setup_phase;
		pslverr_next = setup_phase & ~addr_hit;
		prdata_next = {`IPLR_DW{1'b0}};
		if (setup_phase && !pwrite_i && addr_hit) begin
			// upper half stays zero: registers are 16 bits wide
			prdata_next = {{(`IPLR_DW-`IPLR_RW){1'b0}}, rd_word};
		end
	end

	// register write: the whole register in one go, reserved bits forced to zero
	always @* begin
		irq_level_reg_zero_next = irq_level_reg_zero_reg;
		irq_level_flash_portd_next = irq_level_flash_portd_reg;
		irq_level_serial_ports_next = irq_level_serial_ports_reg;
		irq_level_i2c_err_serial_next = irq_level_i2c_err_serial_reg;
		irq_level_timer_i2c_next = irq_level_timer_i2c_reg;
		// an erroring transfer writes nothing, so a stray address cannot alias
		if (access_done && pwrite_i && !pslverr_o) begin
			case (paddr_i)
				`IPLR_ADDR_ZERO: begin
					// the other fields of this register live elsewhere
					irq_level_reg_zero_next = pwdata_i[`IPLR_RW-1:0] & `IPLR_MASK_ZERO;
				end
				`IPLR_ADDR_FLASH_PORTD: begin
					irq_level_flash_portd_next = pwdata_i[`IPLR_RW-1:0] & `IPLR_MASK_FLASH_PORTD;
				end
				`IPLR_ADDR_SERIAL_PORTS: begin
					irq_level_serial_ports_next = pwdata_i[`IPLR_RW-1:0] & `IPLR_MASK_SERIAL_PORTS;
				end
				`IPLR_ADDR_I2C_ERR_SERIAL: begin
					irq_level_i2c_err_serial_next = pwdata_i[`IPLR_RW-1:0] & `IPLR_MASK_I2C_ERR_SERIAL;
				end
				`IPLR_ADDR_TIMER_I2C: begin
					irq_level_timer_i2c_next = pwdata_i[`IPLR_RW-1:0] & `IPLR_MASK_TIMER_I2C;
				end
				default: begin
					irq_level_reg_zero_next = irq_level_reg_zero_reg; // nothing to write
				end
			endcase
		end
	end

	// register state; every field starts disabled
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_level_reg_zero_reg <= `IPLR_RESET_VAL;
			irq_level_flash_portd_reg <= `IPLR_RESET_VAL;
			irq_level_serial_ports_reg <= `IPLR_RESET_VAL;
			irq_level_i2c_err_serial_reg <= `IPLR_RESET_VAL;
			irq_level_timer_i2c_reg <= `IPLR_RESET_VAL;
			prdata_o <= {`IPLR_DW{1'b0}};
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			irq_level_reg_zero_reg <= irq_level_reg_zero_next;
			irq_level_flash_portd_reg <= irq_level_flash_portd_next;
			irq_level_serial_ports_reg <= irq_level_serial_ports_next;
			irq_level_i2c_err_serial_reg <= irq_level_i2c_err_serial_next;
			irq_level_timer_i2c_reg <= irq_level_timer_i2c_next;
			prdata_o <= prdata_next;
			pready_o <= pready_next;
			pslverr_o <= pslverr_next;
		end
	end

	// source order: the two debug sources first, so they take the upper range
	assign field_next_all = {
		irq_level_timer_i2c_next[15:14], // 23 timer a ch3
		irq_level_timer_i2c_next[13:12], // 22 timer a ch2
		irq_level_timer_i2c_next[11:10], // 21 timer a ch1
		irq_level_timer_i2c_next[9:8], // 20 timer a ch0
		irq_level_timer_i2c_next[7:6], // 19 i2c status
		irq_level_timer_i2c_next[5:4], // 18 i2c transmit
		irq_level_timer_i2c_next[3:2], // 17 i2c receive
		irq_level_timer_i2c_next[1:0], // 16 i2c general call
		irq_level_i2c_err_serial_next[15:14], // 15 i2c error
		irq_level_i2c_err_serial_next[5:4], // 14 async rx full
		irq_level_i2c_err_serial_next[3:2], // 13 async rx error
		irq_level_i2c_err_serial_next[1:0], // 12 async tx idle
		irq_level_serial_ports_next[15:14], // 11 async tx empty
		irq_level_serial_ports_next[9:8], // 10 sync tx empty
		irq_level_serial_ports_next[7:6], // 9 sync rx full
		irq_level_serial_ports_next[5:4], // 8 port a
		irq_level_serial_ports_next[3:2], // 7 port b
		irq_level_serial_ports_next[1:0], // 6 port c
		irq_level_flash_portd_next[15:14], // 5 port d
		irq_level_flash_portd_next[5:4], // 4 flash buffers empty
		irq_level_flash_portd_next[3:2], // 3 flash command complete
		irq_level_flash_portd_next[1:0], // 2 flash error
		irq_level_reg_zero_next[3:2], // 1 debug breakpoint
		irq_level_reg_zero_next[1:0] // 0 debug step counter
	};

	// one decoder per source; fed from next values so outputs track the fields exactly
	genvar gi;
	generate
		for (gi = 0; gi < `IPLR_NUM_SRC; gi = gi + 1) begin : g_src
			iplr_level_dec #(
				.UPPER_RANGE((gi < `IPLR_NUM_UPPER) ? 1 : 0)
			) u_dec (
				.clk_i(clk_i),
				.nrst_i(nrst_i),
				.field_next_i(field_next_all[gi*`IPLR_FIELD_W +: `IPLR_FIELD_W]),
				.irq_i(src_irq_i[gi]),
				.en_o(src_en_o[gi]),
				.level_o(src_level_o[gi*`IPLR_FIELD_W +: `IPLR_FIELD_W]),
				.req_o(src_req_o[gi])
			);
		end
	endgenerate

endmodule // iplr_regs
`default_nettype wire

//--- testbench/iplr_regs_chk.sv
// assertion checker for the interrupt priority level registers
`timescale 1ns/10ps
`default_nettype none
`include "iplr_defines.vh"
module iplr_regs_chk (
	input wire clk_i,
	input wire nrst_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [`IPLR_AW-1:0] paddr_i,
	input wire [`IPLR_DW-1:0] pwdata_i,
	input wire [`IPLR_NUM_SRC-1:0] src_irq_i,
	input wire [`IPLR_DW-1:0] prdata_o,
	input wire pready_o,
	input wire pslverr_o,
	input wire [`IPLR_NUM_SRC-1:0] src_en_o,
	input wire [`IPLR_NUM_SRC*`IPLR_FIELD_W-1:0] src_level_o,
	input wire [`IPLR_NUM_SRC-1:0] src_req_o
);
	wire [`IPLR_NUM_SRC*`IPLR_FIELD_W-1:0] en_wide; // enable spread over its level pair
	wire [`IPLR_NUM_SRC-1:0] is_three; // source reports the top level
	wire setup = psel_i && !penable_i; // apb setup cycle
	wire wr_done = psel_i && penable_i && pwrite_i && pready_o; // write lands here
	genvar g;
	// per-source helpers, so one assertion covers all 24 fields
	generate
		for (g = 0; g < `IPLR_NUM_SRC; g = g + 1) begin : g_src
			assign en_wide[2*g+1:2*g] = {2{src_en_o[g]}};
			assign is_three[g] = &src_level_o[2*g+1:2*g];
		end
	endgenerate
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	property p_ready_after_setup; setup |=> pready_o; endproperty
	a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
	property p_ready_pulse; pready_o |=> !pready_o; endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
	property p_ready_cause; pready_o |-> $past(setup); endproperty
	a_ready_cause: assert property (p_ready_cause) else $error("ready without setup");
	property p_err_quiet; pslverr_o |-> pready_o && prdata_o == 32'h0; endproperty
	a_err_quiet: assert property (p_err_quiet) else $error("error reply malformed");
	property p_rdata_idle; !pready_o |-> prdata_o == 32'h0; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside access");
	property p_rdata_upper; prdata_o[31:16] == 16'h0; endproperty
	a_rdata_upper: assert property (p_rdata_upper) else $error("upper read bits set");
	property p_dis_level; (src_level_o & ~en_wide) == 48'h0; endproperty
	a_dis_level: assert property (p_dis_level) else $error("disabled source has level");
	property p_lower_range; is_three[`IPLR_NUM_SRC-1:2] == 22'h0; endproperty
	a_lower_range: assert property (p_lower_range) else $error("lower source at level three");
	property p_upper_range; {|src_level_o[3:2], |src_level_o[1:0]} == src_en_o[1:0]; endproperty
	a_upper_range: assert property (p_upper_range) else $error("upper source level zero");
	property p_req_gate; src_req_o == ($past(src_irq_i) & src_en_o); endproperty
	a_req_gate: assert property (p_req_gate) else $error("request gating wrong");
	property p_hold; !wr_done |=> $stable(src_level_o) && $stable(src_en_o); endproperty
	a_hold: assert property (p_hold) else $error("levels moved without write");
	c_write: cover property (wr_done);
	c_error: cover property (pslverr_o);
	c_req: cover property (|src_req_o);
endmodule // iplr_regs_chk
bind iplr_regs iplr_regs_chk iplr_regs_chk_i (.clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
	.pwdata_i, .src_irq_i, .prdata_o, .pready_o, .pslverr_o, .src_en_o, .src_level_o, .src_req_o);
`default_nettype wire

//--- testbench/tb_top.sv
// self-checking bench for the interrupt priority level registers
`timescale 1ns/10ps
`default_nettype none
`include "iplr_defines.vh"
module tb_top;
	logic clk_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
	logic [7:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic [23:0] src_irq_i, src_en_o, src_req_o, irq_pat, en_x;
	logic [47:0] src_level_o, lv_x;
	logic [15:0] shadow [5]; // expected register contents
	logic [15:0] mask [5] = '{`IPLR_MASK_ZERO, `IPLR_MASK_FLASH_PORTD, `IPLR_MASK_SERIAL_PORTS,
		`IPLR_MASK_I2C_ERR_SERIAL, `IPLR_MASK_TIMER_I2C};
	int lsb [24] = '{0, 2, 0, 2, 4, 14, 0, 2, 4, 6, 8, 14, 0, 2, 4, 14, 0, 2, 4, 6, 8, 10, 12, 14}; // field lsb
	int ridx [24] = '{0, 0, 1, 1, 1, 1, 2, 2, 2, 2, 2, 2, 3, 3, 3, 3, 4, 4, 4, 4, 4, 4, 4, 4}; // register
	int errors, checks;
	iplr_regs iplr_regs_i (.clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.src_irq_i, .prdata_o, .pready_o, .pslverr_o, .src_en_o, .src_level_o, .src_req_o);
	// free-running 200 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one apb transfer, request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		src_irq_i <= irq_pat;
		@(posedge clk_i);
		penable_i <= 1'b1;
		// no wait-state count is assumed; only the watchdog ends a wait that never finishes
		do begin
			@(posedge clk_i);
		end while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	// rebuild expected enables, levels and requests from the shadow copy
	task automatic expect_outs();
		logic [1:0] c;
		@(negedge clk_i);
		for (int s = 0; s < 24; s++) begin
			c = 2'(shadow[ridx[s]] >> lsb[s]);
			en_x[s] = (c != 2'h0);
			lv_x[2*s+:2] = (c == 2'h0 || s < 2) ? c : c - 2'h1;
		end
		chk("enable", {24'h0, en_x}, {24'h0, src_en_o});
		chk("level", lv_x, src_level_o);
		chk("request", {24'h0, irq_pat & en_x}, {24'h0, src_req_o});
	endtask
	task automatic wr(input int i, input logic [31:0] d);
		apb(1'b1, 8'(i * 4), d);
		shadow[i] = d[15:0] & mask[i];
		chk("write_err", 48'h0, {47'h0, err});
		expect_outs();
	endtask
	task automatic rdc(input int i);
		apb(1'b0, 8'(i * 4), 32'h0);
		chk("rdata", {32'h0, shadow[i]}, {16'h0, rd});
		chk("read_err", 48'h0, {47'h0, err});
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// watchdog against a hung handshake
	initial begin
		#100000;
		errors++;
		tally_and_finish();
	end
	initial begin
		{nrst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, errors, checks} = '0;
		irq_pat = 24'hFFFFFF;
		src_irq_i = irq_pat;
		foreach (shadow[i]) shadow[i] = 16'h0;
		repeat (8) @(posedge clk_i);
		nrst_i <= 1'b1;
		for (int i = 0; i < 5; i++) rdc(i);
		expect_outs();
		// every writable bit set, reserved bits kept zero as software must; upper bus half is ignored
		for (int i = 0; i < 5; i++) begin
			wr(i, {16'hFFFF, mask[i]});
			rdc(i);
		end
		for (int i = 0; i < 5; i++) wr(i, 32'h0);
		// walk codes 1 to 3 through every field, with shifting request patterns
		for (int s = 0; s < 24; s++) begin
			for (int c = 1; c < 4; c++) begin
				irq_pat = {8{3'(c + s)}};
				wr(ridx[s], 32'(c << lsb[s]));
			end
		end
		// refused accesses change nothing
		apb(1'b1, 8'h14, 32'hFFFF);
		chk("unmapped_err", 48'h1, {47'h0, err});
		apb(1'b1, 8'h11, 32'h0);
		chk("misaligned_err", 48'h1, {47'h0, err});
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped_rdata", 48'h0, {16'h0, rd});
		chk("unmapped_rd_err", 48'h1, {47'h0, err});
		rdc(4);
		// reset in mid-run clears every field
		@(posedge clk_i);
		nrst_i <= 1'b0;
		@(posedge clk_i);
		nrst_i <= 1'b1;
		foreach (shadow[i]) shadow[i] = 16'h0;
		for (int i = 0; i < 5; i++) rdc(i);
		expect_outs();
		tally_and_finish();
	end
endmodule // tb_top
`default_nettype wire
